// ---- hw/level_ramp.sv ----
`default_nettype none
module level_ramp #(
	parameter int W = 7
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         clear,
	input  wire logic         tick,
	input  wire logic [W-1:0] target,
	output logic      [W-1:0] level,
	output logic              busy
);
	logic [W-1:0] level_q;
	logic [W-1:0] level_d;
	wire          up   = target > level_q;
	wire          down = target < level_q;

	// Target is read on every tick, so a new code redirects a ramp mid-way
	assign level_d = clear ? '0 : !tick ? level_q
		: up ? level_q + 1'b1 : down ? level_q - 1'b1 : level_q;
	assign level   = level_q;
	assign busy    = up | down;

	always_ff @(posedge clk) begin
		if (!rst_n)
			level_q <= '0;
		else
			level_q <= level_d;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	step_size_a: assert property ($changed(level_q) && !$past(clear) |->
		$past(tick) && (level_q == W'($past(level_q) + 1'b1)
		|| level_q == W'($past(level_q) - 1'b1)))
		else $error("reference moved other than one step on a tick");
	slew_move_a: assert property (tick && !clear && busy |=>
		level_q != $past(level_q))
		else $error("reference did not step on a tick");
endmodule
`default_nettype wire

// ---- hw/phase_pwm.sv ----
`default_nettype none
module phase_pwm #(
	parameter int CW = 11
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          run,
	input  wire logic          nb_run,
	input  wire logic [2:0]    phases,
	input  wire logic [CW-1:0] period,
	input  wire logic [CW-1:0] duty,
	output logic      [3:0]    gate,
	output logic               nb_gate
);
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] nb_cnt_q;
	logic [3:0]    gate_q;
	logic          nb_gate_q;

	function automatic logic [CW-1:0] scale(input logic [CW-1:0] v);
		scale = CW'(((CW+3)'(v) * (CW+3)'(ref_seq_pkg::NB_RATIO_NUM))
			/ (CW+3)'(ref_seq_pkg::NB_RATIO_DEN));
	endfunction

	function automatic logic [CW-1:0] lag(input logic [CW-1:0] p,
		input logic [1:0] slot, input logic [2:0] n);
		lag = CW'(((CW+2)'(p) * (CW+2)'(slot)) / (CW+2)'(n));
	endfunction

	wire [CW-1:0] nb_period = scale(period);
	wire [CW-1:0] nb_duty   = scale(duty);

	for (genvar i = 0; i < 4; i++) begin : g_phase
		// Two-phase uses outputs 0 and 2 at slots 0 and 1
		wire [1:0]    slot = (phases == 3'h2) ? 2'(i / 2) : 2'(i);
		wire          used = (phases == 3'h2) ? (i % 2 == 0) : (i < phases);
		wire [CW:0]   sum  = {1'b0, cnt_q}
			+ {1'b0, lag(period, slot, phases)};
		wire [CW-1:0] pos  = (sum >= {1'b0, period})
			? CW'(sum - {1'b0, period}) : sum[CW-1:0];
		always_ff @(posedge clk) begin
			if (!rst_n)
				gate_q[i] <= 1'b0;
			else
				gate_q[i] <= run & used & (pos < duty);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q     <= '0;
			nb_cnt_q  <= '0;
			nb_gate_q <= 1'b0;
		end else begin
			cnt_q     <= (!run || cnt_q >= period - 1'b1) ? '0 : cnt_q + 1'b1;
			// Free-running, never synchronised to the core counter
			nb_cnt_q  <= (!nb_run || nb_cnt_q >= nb_period - 1'b1)
				? '0 : nb_cnt_q + 1'b1;
			nb_gate_q <= nb_run & (nb_cnt_q < nb_duty);
		end
	end

	assign gate    = gate_q;
	assign nb_gate = nb_gate_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	two_phase_off_a: assert property (phases == 3'h2 |=>
		!gate_q[1] && !gate_q[3])
		else $error("unused gate active in two-phase operation");
	three_phase_off_a: assert property (phases == 3'h3 |=>
		!gate_q[3])
		else $error("fourth gate active in three-phase operation");
	four_phase_c: cover property (run && phases == 3'h4 && gate_q[3]);
endmodule
`default_nettype wire

// ---- hw/ref_seq_pkg.sv ----
`default_nettype none
package ref_seq_pkg;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLOCK_FREQ_KHZ     = 125000;
	localparam int CLOCK_PERIOD_NS    = 8;
	// One 12.5 mV reference step per tick
	localparam int STEP_TIME_NS       = 1000;
	localparam int STEP_CYCLES        =
		(STEP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int PHASE_FREQ_MIN_KHZ = 100;
	localparam int PHASE_FREQ_MAX_KHZ = 1000;
	localparam int PERIOD_MAX_CYCLES  = CLOCK_FREQ_KHZ / PHASE_FREQ_MIN_KHZ;
	localparam int PERIOD_MIN_CYCLES  = CLOCK_FREQ_KHZ / PHASE_FREQ_MAX_KHZ;
	// Northbridge period is 4/5 of the core period (1.25x frequency)
	localparam int NB_RATIO_NUM       = 4;
	localparam int NB_RATIO_DEN       = 5;
	// ---------------------------------------------------------------
	// Register map and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0]  ADDR_CONFIG    = 8'h00;
	localparam logic [7:0]  ADDR_PERIOD    = 8'h04;
	localparam logic [7:0]  ADDR_DUTY      = 8'h08;
	localparam logic [7:0]  ADDR_STATUS    = 8'h0C;
	localparam logic [7:0]  ADDR_NB_STATUS = 8'h10;
	localparam logic [2:0]  PHASES_RESET   = 3'h4;
	localparam logic [10:0] PERIOD_RESET   = 11'h0FA;
	localparam logic [10:0] DUTY_RESET     = 11'h000;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	// ---------------------------------------------------------------
	// Levels, in 12.5 mV units
	// ---------------------------------------------------------------
	localparam logic [6:0]  PAR_TOP_LEVEL  = 7'h7C;
	localparam logic [6:0]  PAR_FINE_BASE  = 7'h5D;
	localparam logic [6:0]  BOOT_TOP_LEVEL = 7'h58;
	localparam logic [6:0]  FIX_TOP_LEVEL  = 7'h70;

	typedef logic [6:0] level_t;
	typedef enum logic [1:0] {MODE_IDLE, MODE_PARALLEL, MODE_SERIAL} mode_t;

	// 25 mV steps for the lower half of the codes, 12.5 mV steps for the upper half
	function automatic level_t parallel_level(input logic [5:0] c);
		parallel_level = c[5] ? PAR_FINE_BASE - {1'b0, c}
			: PAR_TOP_LEVEL - {c, 1'b0};
	endfunction

	function automatic level_t boot_level(input logic [1:0] b);
		boot_level = BOOT_TOP_LEVEL - {2'h0, b, 3'h0};
	endfunction

	function automatic level_t fixed_level(input logic [1:0] b);
		fixed_level = FIX_TOP_LEVEL - {1'h0, b, 4'h0};
	endfunction
endpackage
`default_nettype wire

// ---- hw/vid_reference_sequencer.sv ----
`default_nettype none
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module vid_reference_sequencer #(
	parameter int ADDR_W = 8
) (
	input  wire logic              CLOCK,
	input  wire logic              RST_N,
	input  wire logic              ENABLE,
	input  wire logic [5:0]        VOLTAGE_CODE,
	input  wire logic              HOST_POWER_GOOD,
	input  wire logic              FIXED_DEBUG_MODE_N,
	output logic                   GATE_OUT_1,
	output logic                   GATE_OUT_2,
	output logic                   GATE_OUT_3,
	output logic                   GATE_OUT_4,
	output logic                   NORTHBRIDGE_RAIL_GATE,
	output logic                   NORTHBRIDGE_RAIL_GATE_OE,
	output logic [6:0]             CORE_REF_LEVEL,
	output logic [6:0]             NORTHBRIDGE_RAIL_REF_LEVEL,
	input  wire logic [ADDR_W-1:0] AWADDR,
	input  wire logic [2:0]        AWPROT,
	input  wire logic              AWVALID,
	output logic                   AWREADY,
	input  wire logic [31:0]       WDATA,
	input  wire logic [3:0]        WSTRB,
	input  wire logic              WVALID,
	output logic                   WREADY,
	output logic [1:0]             BRESP,
	output logic                   BVALID,
	input  wire logic              BREADY,
	input  wire logic [ADDR_W-1:0] ARADDR,
	input  wire logic [2:0]        ARPROT,
	input  wire logic              ARVALID,
	output logic                   ARREADY,
	output logic [31:0]            RDATA,
	output logic [1:0]             RRESP,
	output logic                   RVALID,
	input  wire logic              RREADY
);
	localparam int TW = $clog2(ref_seq_pkg::STEP_CYCLES);

	// ---------------------------------------------------------------
	// Start-up capture and mode
	// ---------------------------------------------------------------
	logic                  enable_q;
	ref_seq_pkg::mode_t    mode_q;
	ref_seq_pkg::mode_t    mode_d;
	logic [1:0]            boot_q;
	logic [5:0]            code_at_en_q;
	logic                  code_seen_q;
	logic                  nb_oe_q;
	logic [TW-1:0]         tick_cnt_q;

	wire enable_rise = ENABLE & ~enable_q;
	// Shared pins: bit 2 is the serial clock, bit 3 the serial data
	wire [1:0] pin_pair = {VOLTAGE_CODE[2], VOLTAGE_CODE[3]};
	wire is_active = mode_q != ref_seq_pkg::MODE_IDLE;
	wire is_par    = mode_q == ref_seq_pkg::MODE_PARALLEL;
	wire fixed_on  = is_active & ~FIXED_DEBUG_MODE_N;
	// Serial transactions are not decoded, so serial mode simply holds boot
	wire nb_on     = fixed_on | (mode_q == ref_seq_pkg::MODE_SERIAL);
	// Power-good is deliberately not looked at in parallel mode
	wire code_new  = is_par
		& (code_seen_q | (VOLTAGE_CODE != code_at_en_q));

	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			ref_seq_pkg::MODE_IDLE:
				if (enable_rise)
					mode_d = VOLTAGE_CODE[1] ? ref_seq_pkg::MODE_PARALLEL
						: ref_seq_pkg::MODE_SERIAL;
			ref_seq_pkg::MODE_PARALLEL,
			ref_seq_pkg::MODE_SERIAL:
				if (!ENABLE)
					mode_d = ref_seq_pkg::MODE_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			enable_q     <= 1'b0;
			mode_q       <= ref_seq_pkg::MODE_IDLE;
			boot_q       <= 2'h0;
			code_at_en_q <= 6'h00;
			code_seen_q  <= 1'b0;
			nb_oe_q      <= 1'b0;
		end else begin
			enable_q <= ENABLE;
			mode_q   <= mode_d;
			nb_oe_q  <= nb_on;
			if (enable_rise) begin
				boot_q       <= pin_pair;
				code_at_en_q <= VOLTAGE_CODE;
			end
			code_seen_q <= code_new;
		end
	end

	// ---------------------------------------------------------------
	// Targets and ramps
	// ---------------------------------------------------------------
	ref_seq_pkg::level_t core_target;
	ref_seq_pkg::level_t nb_target;
	ref_seq_pkg::level_t core_ref;
	ref_seq_pkg::level_t nb_ref;
	logic                core_busy;

	wire ref_seq_pkg::level_t boot_lvl = ref_seq_pkg::boot_level(boot_q);
	wire ref_seq_pkg::level_t fix_lvl  = ref_seq_pkg::fixed_level(pin_pair);
	wire ref_seq_pkg::level_t par_lvl  =
		ref_seq_pkg::parallel_level(VOLTAGE_CODE);

	// A live code overrides boot at once, even mid-ramp
	assign core_target = !is_active ? '0 : fixed_on ? fix_lvl
		: code_new ? par_lvl : boot_lvl;
	assign nb_target   = !nb_on ? '0 : fixed_on ? fix_lvl : boot_lvl;

	// Rate timer restarts with the mode so the first step is a full tick
	wire tick = tick_cnt_q == '0;
	always_ff @(posedge CLOCK) begin
		if (!RST_N || !is_active)
			tick_cnt_q <= TW'(ref_seq_pkg::STEP_CYCLES - 1);
		else
			tick_cnt_q <= tick ? TW'(ref_seq_pkg::STEP_CYCLES - 1)
				: tick_cnt_q - 1'b1;
	end

	level_ramp #(.W(7)) u_core_ramp (
		.clk    (CLOCK),
		.rst_n  (RST_N),
		.clear  (!is_active),
		.tick   (tick),
		.target (core_target),
		.level  (core_ref),
		.busy   (core_busy)
	);

	level_ramp #(.W(7)) u_nb_ramp (
		.clk    (CLOCK),
		.rst_n  (RST_N),
		.clear  (!nb_on),
		.tick   (tick),
		.target (nb_target),
		.level  (nb_ref),
		.busy   ()
	);

	assign CORE_REF_LEVEL             = core_ref;
	assign NORTHBRIDGE_RAIL_REF_LEVEL = nb_ref;

	// ---------------------------------------------------------------
	// Registers over AXI4-Lite
	// ---------------------------------------------------------------
	logic [2:0]        phases_q;
	logic [10:0]       period_q;
	logic [10:0]       duty_q;
	logic              aw_full_q;
	logic              w_full_q;
	logic              bvalid_q;
	logic              rvalid_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic [1:0]        bresp_q;
	logic [1:0]        rresp_q;
	logic [31:0]       rdata_q;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		for (int b = 0; b < 4; b++)
			merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
	endfunction

	wire do_write = aw_full_q & w_full_q & ~bvalid_q;
	wire sel_cfg  = aw_addr_q == ADDR_W'(ref_seq_pkg::ADDR_CONFIG);
	wire sel_per  = aw_addr_q == ADDR_W'(ref_seq_pkg::ADDR_PERIOD);
	wire sel_duty = aw_addr_q == ADDR_W'(ref_seq_pkg::ADDR_DUTY);
	wire sel_ro   = aw_addr_q == ADDR_W'(ref_seq_pkg::ADDR_STATUS)
		|| aw_addr_q == ADDR_W'(ref_seq_pkg::ADDR_NB_STATUS);
	wire [31:0] cfg_word  = merge({29'h0, phases_q}, wdata_q, wstrb_q);
	wire [31:0] per_word  = merge({21'h0, period_q}, wdata_q, wstrb_q);
	wire [31:0] duty_word = merge({21'h0, duty_q}, wdata_q, wstrb_q);
	// Phase counts other than 2..4 are dropped, keeping the old value
	wire cfg_ok = cfg_word[2:0] >= 3'h2 && cfg_word[2:0] <= 3'h4;

	// Out-of-range frequencies are clamped to the supported band
	wire [10:0] period_eff =
		(period_q < 11'(ref_seq_pkg::PERIOD_MIN_CYCLES))
		? 11'(ref_seq_pkg::PERIOD_MIN_CYCLES)
		: (period_q > 11'(ref_seq_pkg::PERIOD_MAX_CYCLES))
		? 11'(ref_seq_pkg::PERIOD_MAX_CYCLES) : period_q;

	wire [31:0] status_word = {10'h0, boot_q, is_active, core_busy,
		fixed_on, is_par, 1'b0, core_target, 1'b0, core_ref};
	wire rd_cfg  = ARADDR == ADDR_W'(ref_seq_pkg::ADDR_CONFIG);
	wire rd_per  = ARADDR == ADDR_W'(ref_seq_pkg::ADDR_PERIOD);
	wire rd_duty = ARADDR == ADDR_W'(ref_seq_pkg::ADDR_DUTY);
	wire rd_st   = ARADDR == ADDR_W'(ref_seq_pkg::ADDR_STATUS);
	wire rd_nb   = ARADDR == ADDR_W'(ref_seq_pkg::ADDR_NB_STATUS);
	wire rd_hit  = rd_cfg | rd_per | rd_duty | rd_st | rd_nb;
	wire [31:0] rd_word = rd_cfg ? {29'h0, phases_q}
		: rd_per ? {21'h0, period_q} : rd_duty ? {21'h0, duty_q}
		: rd_st ? status_word : rd_nb ? {25'h0, nb_ref} : 32'h0;

	assign AWREADY = ~aw_full_q;
	assign WREADY  = ~w_full_q;
	assign ARREADY = ~rvalid_q;
	assign BVALID  = bvalid_q;
	assign BRESP   = bresp_q;
	assign RVALID  = rvalid_q;
	assign RRESP   = rresp_q;
	assign RDATA   = rdata_q;

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= ref_seq_pkg::RESP_OKAY;
			aw_addr_q <= '0;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
		end else begin
			if (AWVALID && !aw_full_q) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= AWADDR;
			end else if (do_write) begin
				aw_full_q <= 1'b0;
			end
			if (WVALID && !w_full_q) begin
				w_full_q <= 1'b1;
				wdata_q  <= WDATA;
				wstrb_q  <= WSTRB;
			end else if (do_write) begin
				w_full_q <= 1'b0;
			end
			if (do_write) begin
				bvalid_q <= 1'b1;
				bresp_q  <= (sel_cfg | sel_per | sel_duty | sel_ro)
					? ref_seq_pkg::RESP_OKAY : ref_seq_pkg::RESP_SLVERR;
			end else if (BREADY) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			phases_q <= ref_seq_pkg::PHASES_RESET;
			period_q <= ref_seq_pkg::PERIOD_RESET;
			duty_q   <= ref_seq_pkg::DUTY_RESET;
		end else if (do_write) begin
			if (sel_cfg && cfg_ok)
				phases_q <= cfg_word[2:0];
			if (sel_per)
				period_q <= per_word[10:0];
			if (sel_duty)
				duty_q <= duty_word[10:0];
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			rvalid_q <= 1'b0;
			rresp_q  <= ref_seq_pkg::RESP_OKAY;
			rdata_q  <= 32'h0;
		end else if (ARVALID && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rresp_q  <= rd_hit ? ref_seq_pkg::RESP_OKAY
				: ref_seq_pkg::RESP_SLVERR;
			rdata_q  <= rd_word;
		end else if (RREADY) begin
			rvalid_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Phase generation
	// ---------------------------------------------------------------
	logic [3:0] gates;
	logic       nb_gate;

	phase_pwm #(.CW(11)) u_pwm (
		.clk     (CLOCK),
		.rst_n   (RST_N),
		.run     (is_active),
		.nb_run  (nb_on),
		.phases  (phases_q),
		.period  (period_eff),
		.duty    (duty_q),
		.gate    (gates),
		.nb_gate (nb_gate)
	);

	assign GATE_OUT_1               = gates[0];
	assign GATE_OUT_2               = gates[1];
	assign GATE_OUT_3               = gates[2];
	assign GATE_OUT_4               = gates[3];
	assign NORTHBRIDGE_RAIL_GATE    = nb_gate;
	assign NORTHBRIDGE_RAIL_GATE_OE = nb_oe_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	boot_capture_a: assert property (enable_rise && !is_active |=>
		boot_q == $past(pin_pair))
		else $error("boot code not latched at enable rise");
	boot_map_a: assert property (enable_rise && !is_active
		&& pin_pair == 2'h0 && FIXED_DEBUG_MODE_N ##1
		FIXED_DEBUG_MODE_N && $stable(VOLTAGE_CODE) && ENABLE
		|-> core_target == 7'h58)
		else $error("boot code 00 did not target 1.1 V");
	mode_par_a: assert property (enable_rise && !is_active
		&& VOLTAGE_CODE[1] |=> mode_q == ref_seq_pkg::MODE_PARALLEL)
		else $error("parallel mode not selected");
	mode_ser_a: assert property (enable_rise && !is_active
		&& !VOLTAGE_CODE[1] |=> mode_q == ref_seq_pkg::MODE_SERIAL)
		else $error("serial mode not selected");
	soft_start_a: assert property ($rose(is_active) |->
		core_ref == 7'h00 ##1 core_ref == 7'h00)
		else $error("soft start did not begin from zero");
	code_follow_a: assert property (is_par && !fixed_on
		&& $changed(VOLTAGE_CODE) |-> core_target == par_lvl)
		else $error("new parallel code did not retarget");
	nb_off_a: assert property (is_par && FIXED_DEBUG_MODE_N |=>
		!NORTHBRIDGE_RAIL_GATE_OE && !NORTHBRIDGE_RAIL_GATE)
		else $error("northbridge driven in parallel mode");
	fixed_both_a: assert property (fixed_on |->
		core_target == nb_target && core_target == fix_lvl)
		else $error("fixed mode levels differ between sections");

	par_start_c: cover property (enable_rise && VOLTAGE_CODE[1]);
	mid_ramp_c: cover property (is_par && core_busy && $changed(VOLTAGE_CODE));
	fixed_c: cover property (fixed_on && nb_oe_q);
endmodule
`default_nettype wire

// ---- verif/host_cpu.sv ----
`default_nettype none
module host_cpu (
	input  wire logic       clk,
	output logic            enable,
	output logic      [5:0] code,
	output logic            good,
	output logic            fix_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		enable = 1'b0;
		code = 6'h00;
		good = 1'b0;
		fix_n = 1'b1;
	end
	// Pins settle one edge ahead so the strap is clean at enable rise
	task automatic power_up(input logic [5:0] c);
		@(posedge clk) code <= c;
		@(posedge clk) enable <= 1'b1;
	endtask
	task automatic drive(input logic [5:0] c, input logic g, input logic f);
		@(posedge clk);
		code <= c;
		good <= g;
		fix_n <= f;
	endtask
	task automatic power_down();
		@(posedge clk) enable <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- verif/tb_vid_reference_sequencer.sv ----
`default_nettype none
module tb_vid_reference_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CP = 250;
	localparam int LIMIT = 40000;
	logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, watch;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, d;
	logic [1:0] r;
	logic [6:0] prev;
	wire logic enable, good, fix_n, nb_gate, nb_oe;
	wire logic awready, wready, bvalid, arready, rvalid;
	wire logic [5:0] code;
	wire logic [3:0] gates;
	wire logic [6:0] core_ref, nb_ref;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	int failures, comparisons, cyc, gap, t0;
	logic [5:0] codes[4] = '{6'h00, 6'h1F, 6'h20, 6'h3E};
	host_cpu host (.clk(clk), .enable(enable), .code(code), .good(good),
		.fix_n(fix_n));
	vid_reference_sequencer dut (.CLOCK(clk), .RST_N(rst_n),
		.ENABLE(enable), .VOLTAGE_CODE(code), .HOST_POWER_GOOD(good),
		.FIXED_DEBUG_MODE_N(fix_n), .GATE_OUT_1(gates[0]),
		.GATE_OUT_2(gates[1]), .GATE_OUT_3(gates[2]), .GATE_OUT_4(gates[3]),
		.NORTHBRIDGE_RAIL_GATE(nb_gate), .NORTHBRIDGE_RAIL_GATE_OE(nb_oe),
		.CORE_REF_LEVEL(core_ref), .NORTHBRIDGE_RAIL_REF_LEVEL(nb_ref),
		.AWADDR(awaddr), .AWPROT(3'h0), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
		.ARPROT(3'h0), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
		.RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
	// ----
	// Checking
	// ----
	task automatic conclude();
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// Ramp watcher: every move is one unit and no faster than the tick
	always @(negedge clk) begin
		cyc++;
		gap++;
		if (watch && core_ref !== prev) begin
			chk("ramp step", 1, {31'h0, ((core_ref - prev) === 7'h01 ||
				(prev - core_ref) === 7'h01) &&
				gap >= ref_seq_pkg::STEP_CYCLES});
			gap = 0;
		end
		prev = core_ref;
		// Timeout last, so nothing in this process runs after the verdict
		if (cyc == LIMIT) begin
			failures++;
			conclude();
		end
	end
	// ----
	// Bus access
	// ----
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge clk);
			ta = ta | (awvalid & awready);
			tw = tw | (wvalid & wready);
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		do @(negedge clk); while (bvalid !== 1'b1);
		chk("bresp", 32'(ref_seq_pkg::RESP_OKAY), 32'(bresp));
		@(posedge clk) bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge clk); while (arready !== 1'b1);
		@(posedge clk) arvalid <= 1'b0;
		do @(negedge clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		@(posedge clk) rready <= 1'b0;
	endtask
	task automatic seek(input logic [6:0] v);
		while (core_ref !== v) @(negedge clk);
	endtask
	task automatic phase_chk(input int n);
		int first[4];
		int e, t;
		logic [3:0] p, seen;
		axw(ref_seq_pkg::ADDR_CONFIG, 32'(n));
		repeat (600) @(negedge clk);
		first = '{-1, -1, -1, -1};
		p = gates;
		seen = 4'h0;
		for (t = 0; t < CP + 10; t++) begin
			@(negedge clk);
			for (int k = 0; k < 4; k++)
				if (gates[k] && !p[k] && first[k] < 0) first[k] = t;
			seen = seen | gates;
			p = gates;
		end
		chk("active gates", n == 2 ? 5 : n == 3 ? 7 : 15, 32'(seen));
		for (int k = 1; k < 4; k++) if (first[k] >= 0) begin
			e = CP * (n == 2 ? k / 2 : k) / n;
			t = (first[k] - first[0] + CP) % CP;
			chk("phase offset", 1, {31'h0, (t >= e - 1 && t <= e + 1) ||
				(t >= CP - e - 1 && t <= CP - e + 1)});
		end
	endtask
	// ----
	// Sequence
	// ----
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready, watch} = 7'h00;
		{awaddr, araddr, wdata} = 48'h0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd(ref_seq_pkg::ADDR_CONFIG);
		chk("config", 4, d);
		rd(ref_seq_pkg::ADDR_PERIOD);
		chk("period", CP, d);
		rd(8'h14);
		chk("unmapped", {30'h0, ref_seq_pkg::RESP_SLVERR}, {d[29:0], r});
		host.power_up(6'h02);
		watch = 1'b1;
		gap = 0;
		rd(ref_seq_pkg::ADDR_STATUS);
		chk("mode boot", 32'h000D5800, d & 32'h003F7F00);
		chk("nb oe", 0, 32'(nb_oe));
		chk("nb ref off", 0, 32'(nb_ref));
		host.drive(6'h02, 1'b1, 1'b1);
		seek(7'h03);
		rd(ref_seq_pkg::ADDR_STATUS);
		chk("target", 88, 32'(d[14:8]));
		foreach (codes[i]) begin
			host.drive(codes[i], 1'b0, 1'b1);
			rd(ref_seq_pkg::ADDR_STATUS);
			chk("decode", codes[i] < 32 ? 124 - 2 * codes[i] : 93 - codes[i],
				32'(d[14:8]));
		end
		seek(7'd31);
		host.drive(6'h10, 1'b0, 1'b1);
		seek(7'd41);
		host.drive(6'h3F, 1'b0, 1'b1);
		rd(ref_seq_pkg::ADDR_STATUS);
		chk("retarget", 30, 32'(d[14:8]));
		seek(7'd30);
		axw(ref_seq_pkg::ADDR_DUTY, 32'd50);
		for (int n = 2; n <= 4; n++) phase_chk(n);
		axw(ref_seq_pkg::ADDR_CONFIG, 32'd5);
		rd(ref_seq_pkg::ADDR_CONFIG);
		chk("bad phases", 4, d);
		watch = 1'b0;
		host.power_down();
		repeat (4) @(negedge clk);
		host.power_up(6'h04);
		watch = 1'b1;
		gap = 0;
		host.drive(6'h35, 1'b1, 1'b1);
		rd(ref_seq_pkg::ADDR_STATUS);
		chk("serial", 32'h002C4800, d & 32'h003F7F00);
		chk("nb oe", 1, 32'(nb_oe));
		do @(negedge clk); while (nb_gate !== 1'b0);
		do @(negedge clk); while (nb_gate !== 1'b1);
		t0 = cyc;
		do @(negedge clk); while (nb_gate !== 1'b0);
		do @(negedge clk); while (nb_gate !== 1'b1);
		chk("nb period", CP * 4 / 5, 32'(cyc - t0));
		chk("nb ref", 32'(core_ref), 32'(nb_ref));
		host.drive(6'h0C, 1'b1, 1'b0);
		rd(ref_seq_pkg::ADDR_STATUS);
		chk("fixed 11", 32'h00024000, d & 32'h00027F00);
		host.drive(6'h00, 1'b1, 1'b0);
		rd(ref_seq_pkg::ADDR_STATUS);
		chk("fixed 00", 112, 32'(d[14:8]));
		conclude();
	end
endmodule
`default_nettype wire
